/* File: rtl/packet_buffer_controller.sv */
`timescale 1ns/100ps
`default_nettype none
module packet_buffer_controller #(
  parameter int FIFO_DEPTH = pbc_pkg::DESC_DEPTH
) (
  input wire logic mclk_i, // System clock, 20 MHz.
  input wire logic nrst_i, // Asynchronous reset, active low.
  input wire logic [7:0] sfr_addr_i, // Register address.
  input wire logic sfr_wr_i, // Register write strobe.
  input wire logic sfr_rd_i, // Register read strobe.
  input wire logic [7:0] sfr_wdata_i, // Register write data.
  output logic [7:0] sfr_rdata_o, // Register read data.
  input wire logic rx_start_i, // Frame begins.
  input wire logic rx_valid_i, // Receive byte strobe.
  input wire logic [7:0] rx_data_i, // Receive byte.
  input wire logic rx_end_i, // Frame ends or is aborted.
  input wire logic rx_ok_i, // Frame is valid, with rx_end_i.
  input wire logic [31:0] rx_status_i, // Receive status word.
  output logic tx_req_o, // Transmit request pulse.
  output logic [1:0] tx_mode_o, // Transmit variant.
  output logic tx_valid_o, // Transmit byte valid.
  output logic [7:0] tx_data_o, // Transmit byte.
  output logic tx_last_o, // Last byte of frame.
  input wire logic tx_ready_i, // MAC takes byte.
  input wire logic tx_done_i, // Transmission ends or aborts.
  input wire logic [31:0] tx_status_i, // Transmit status word.
  output logic rx_event_o, // Packet received pulse.
  output logic tx_event_o, // Packet sent pulse.
  output logic sleep_o, // Sleep mode level.
  output logic [31:0] mac_ctrl_o // MAC control register.
);
  logic [7:0] pkt_mem [pbc_pkg::MEM_BYTES];
  logic [31:0] mac_control_register [pbc_pkg::CSR_COUNT];
  logic [31:0] csr_shift;
  logic [7:0] csr_addr;
  logic [2:0] csr_busy;
  logic [4:0] split;
  logic flush_en;
  logic rx_buffer_full;
  logic [3:0] last_cmd;
  logic busy;
  logic [7:0] next_rdata;
  logic wr_cmd;
  logic [3:0] cmd;
  logic cmd_known;
  logic do_flush;
  logic do_inval;
  logic csr_ok;
  logic [3:0] csr_idx;
  logic csr_wr_go;
  logic csr_rd_go;
  pbc_pkg::rx_state_type rx_state;
  logic [4:0] head;
  logic [4:0] wpage;
  logic [4:0] spage;
  logic [7:0] woff;
  logic [2:0] npages;
  logic [5:0] used;
  logic [2:0] pend;
  logic room;
  logic rx_open;
  logic rx_push;
  logic rbf_set;
  pbc_pkg::tx_state_type tx_state;
  logic [1:0] wr_idx;
  logic [10:0] tx_count;
  logic [4:0] tx_spage;
  logic [4:0] tx_page;
  logic [7:0] tx_off;
  logic [10:0] tx_left;
  logic tx_go;
  logic tx_fin;

  byte_stream_if #(.W(8)) desc_in ();
  byte_stream_if #(.W(8)) desc_out ();
  byte_stream_if #(.W(8)) txq_in ();
  byte_stream_if #(.W(8)) txq_out ();

  function automatic logic [12:0] baddr(input logic [4:0] page, input logic [7:0] off);
    baddr = {page, off};
  endfunction : baddr

  desc_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_desc (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .flush_i(do_flush),
    .in_s(desc_in),
    .out_s(desc_out)
  );

  two_entry_buffer #(.W(8)) u_txq (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .in_s(txq_in),
    .out_s(txq_out)
  );

  assign wr_cmd = sfr_wr_i && sfr_addr_i == pbc_pkg::SFR_BUF_CMD;
  assign cmd = sfr_wdata_i[3:0];
  assign cmd_known = cmd inside {pbc_pkg::CMD_NOP, pbc_pkg::CMD_INVALIDATE,
      pbc_pkg::CMD_FLUSH, pbc_pkg::CMD_TX_NORMAL, pbc_pkg::CMD_TX_NO_PAD,
      pbc_pkg::CMD_TX_NO_CRC, pbc_pkg::CMD_CSR_WRITE, pbc_pkg::CMD_CSR_READ,
      pbc_pkg::CMD_SLEEP_ON, pbc_pkg::CMD_SLEEP_OFF};
  assign do_flush = wr_cmd && cmd == pbc_pkg::CMD_FLUSH;
  assign do_inval = wr_cmd && cmd == pbc_pkg::CMD_INVALIDATE;
  assign csr_ok = csr_addr[1:0] == 2'b00 && csr_addr <= pbc_pkg::CSR_LAST_ADDR;
  assign csr_idx = csr_addr[5:2];
  assign csr_wr_go = wr_cmd && cmd == pbc_pkg::CMD_CSR_WRITE;
  assign csr_rd_go = wr_cmd && cmd == pbc_pkg::CMD_CSR_READ;
  assign busy = csr_busy != 3'h0 || tx_state != pbc_pkg::TX_IDLE;
  assign mac_ctrl_o = mac_control_register[pbc_pkg::CSR_IDX_CTRL];

  // Register readback; reads of the data port pop the descriptor queue.
  always_comb begin
    next_rdata = 8'h00;
    if (sfr_addr_i == pbc_pkg::SFR_CSR_DATA) begin
      next_rdata = csr_shift[31:24];
    end else if (sfr_addr_i == pbc_pkg::SFR_CSR_ADDR) begin
      next_rdata = csr_addr;
    end else if (sfr_addr_i == pbc_pkg::SFR_SPLIT) begin
      next_rdata = {flush_en, rx_buffer_full, 1'b0, split};
    end else if (sfr_addr_i == pbc_pkg::SFR_BUF_DATA) begin
      next_rdata = desc_out.valid ? desc_out.data : 8'h00;
    end else if (sfr_addr_i == pbc_pkg::SFR_BUF_CMD) begin
      next_rdata = {busy, 3'b000, last_cmd};
    end
  end

  assign desc_out.ready = sfr_rd_i && sfr_addr_i == pbc_pkg::SFR_BUF_DATA;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) sfr_rdata_o <= 8'h00;
    else if (sfr_rd_i) sfr_rdata_o <= next_rdata;
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      split <= pbc_pkg::SPLIT_RST;
      flush_en <= 1'b0;
      csr_addr <= 8'h00;
      last_cmd <= pbc_pkg::CMD_NOP;
      sleep_o <= 1'b0;
    end else begin
      if (sfr_wr_i && sfr_addr_i == pbc_pkg::SFR_SPLIT) begin
        split <= sfr_wdata_i[4:0];
        flush_en <= sfr_wdata_i[7];
      end
      if (sfr_wr_i && sfr_addr_i == pbc_pkg::SFR_CSR_ADDR) csr_addr <= sfr_wdata_i;
      if (wr_cmd && cmd_known) last_cmd <= cmd;
      if (wr_cmd && cmd == pbc_pkg::CMD_SLEEP_ON) sleep_o <= 1'b1;
      else if (wr_cmd && cmd == pbc_pkg::CMD_SLEEP_OFF) sleep_o <= 1'b0;
    end
  end

  // Control register access takes a fixed number of cycles, shown on the busy bit.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      csr_busy <= 3'h0;
      csr_shift <= 32'h00000000;
      for (int i = 0; i < pbc_pkg::CSR_COUNT; i++) mac_control_register[i] <= pbc_pkg::CSR_RST_OTHER;
      mac_control_register[pbc_pkg::CSR_IDX_CTRL] <= pbc_pkg::CSR_RST_CTRL;
      mac_control_register[pbc_pkg::CSR_IDX_ADDR_HI] <= pbc_pkg::CSR_RST_ADDR_HI;
    end else begin
      if (csr_wr_go || csr_rd_go) csr_busy <= pbc_pkg::CSR_BUSY_CYCLES;
      else if (csr_busy != 3'h0) csr_busy <= csr_busy - 1'b1;
      if (csr_wr_go && csr_ok) mac_control_register[csr_idx] <= csr_shift;
      if (csr_rd_go) csr_shift <= csr_ok ? mac_control_register[csr_idx] : 32'h00000000;
      else if (sfr_wr_i && sfr_addr_i == pbc_pkg::SFR_CSR_DATA)
        csr_shift <= {csr_shift[23:0], sfr_wdata_i};
      else if (sfr_rd_i && sfr_addr_i == pbc_pkg::SFR_CSR_DATA)
        csr_shift <= {csr_shift[23:0], 8'h00};
    end
  end

  // Receive side: pages 0 .. split-1 form a circular area.
  assign rx_open = !rx_buffer_full && used < {1'b0, split};
  assign room = npages != pbc_pkg::MAX_PAGES && ({3'b000, npages} + used) < {1'b0, split};
  assign rx_push = rx_state == pbc_pkg::RX_STORE && rx_end_i && rx_ok_i && !do_flush
      && desc_in.ready;
  assign desc_in.valid = rx_push;
  assign desc_in.data = {npages, spage};
  assign desc_in.last = 1'b0;
  assign rbf_set = (rx_state == pbc_pkg::RX_IDLE && rx_start_i && used >= {1'b0, split})
      || (rx_state == pbc_pkg::RX_STORE && rx_valid_i && !rx_end_i
      && woff == pbc_pkg::PAGE_LAST && !room);

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_buffer_full <= 1'b0;
    end else if (rbf_set) begin
      rx_buffer_full <= 1'b1;
    end else if (do_flush || (sfr_wr_i && sfr_addr_i == pbc_pkg::SFR_SPLIT && !sfr_wdata_i[6])) begin
      rx_buffer_full <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_state <= pbc_pkg::RX_IDLE;
      wpage <= 5'h00;
      spage <= 5'h00;
      woff <= 8'h00;
      npages <= 3'h0;
    end else begin
      case (rx_state)
        pbc_pkg::RX_IDLE: begin
          if (rx_start_i && !rx_open) begin
            rx_state <= pbc_pkg::RX_DROP;
          end else if (rx_start_i) begin
            rx_state <= pbc_pkg::RX_STORE;
            spage <= head;
            wpage <= head;
            woff <= pbc_pkg::DATA_OFFSET;
            npages <= 3'h1;
          end
        end
        pbc_pkg::RX_STORE: begin
          if (do_flush) begin
            rx_state <= pbc_pkg::RX_DROP;
          end else if (rx_end_i) begin
            rx_state <= pbc_pkg::RX_IDLE;
          end else if (rx_valid_i) begin
            woff <= woff + 1'b1;
            if (woff == pbc_pkg::PAGE_LAST && room) begin
              wpage <= (wpage == split - 1'b1) ? 5'h00 : wpage + 1'b1;
              npages <= npages + 1'b1;
            end else if (woff == pbc_pkg::PAGE_LAST) begin
              rx_state <= pbc_pkg::RX_DROP;
            end
          end
        end
        default: begin
          if (rx_end_i) rx_state <= pbc_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Pages are released when software invalidates the packet it last popped.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      head <= 5'h00;
      used <= 6'h00;
      pend <= 3'h0;
    end else if (do_flush) begin
      head <= 5'h00;
      used <= 6'h00;
      pend <= 3'h0;
    end else begin
      if (rx_push) head <= (wpage == split - 1'b1) ? 5'h00 : wpage + 1'b1;
      used <= used + (rx_push ? {3'b000, npages} : 6'h00)
          - (do_inval ? {3'b000, pend} : 6'h00);
      if (desc_out.ready && desc_out.valid) pend <= desc_out.data[7:5];
      else if (do_inval) pend <= 3'h0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rx_state == pbc_pkg::RX_STORE && rx_valid_i && !rx_end_i) begin
      pkt_mem[baddr(wpage, woff)] <= rx_data_i;
    end
    for (int i = 0; i < pbc_pkg::STATUS_BYTES; i++) begin
      if (rx_push) pkt_mem[baddr(spage, 8'(i))] <= rx_status_i[8*i +: 8];
      if (tx_fin) pkt_mem[baddr(tx_spage, 8'(i))] <= tx_status_i[8*i +: 8];
    end
  end

  // Transmit side.
  assign tx_go = wr_cmd && tx_state == pbc_pkg::TX_IDLE && cmd inside
      {pbc_pkg::CMD_TX_NORMAL, pbc_pkg::CMD_TX_NO_PAD, pbc_pkg::CMD_TX_NO_CRC};
  assign tx_fin = tx_state != pbc_pkg::TX_IDLE && tx_done_i;
  assign txq_in.valid = tx_state == pbc_pkg::TX_FEED;
  assign txq_in.data = pkt_mem[baddr(tx_page, tx_off)];
  assign txq_in.last = tx_left == 11'h001;
  assign txq_out.ready = tx_ready_i;
  assign tx_valid_o = txq_out.valid;
  assign tx_data_o = txq_out.data;
  assign tx_last_o = txq_out.last;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_idx <= 2'h0;
      tx_count <= 11'h000;
      tx_spage <= 5'h00;
    end else if (tx_go) begin
      wr_idx <= 2'h0;
    end else if (sfr_wr_i && sfr_addr_i == pbc_pkg::SFR_BUF_DATA) begin
      case (wr_idx)
        2'h0: tx_count[10:8] <= sfr_wdata_i[2:0];
        2'h1: tx_count[7:0] <= sfr_wdata_i;
        default: tx_spage <= sfr_wdata_i[4:0];
      endcase
      wr_idx <= (wr_idx == 2'h2) ? 2'h0 : wr_idx + 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_state <= pbc_pkg::TX_IDLE;
      tx_page <= 5'h00;
      tx_off <= 8'h00;
      tx_left <= 11'h000;
    end else begin
      case (tx_state)
        pbc_pkg::TX_IDLE: begin
          if (tx_go) begin
            tx_state <= (tx_count == 11'h000) ? pbc_pkg::TX_WAIT : pbc_pkg::TX_FEED;
            tx_page <= tx_spage;
            tx_off <= pbc_pkg::DATA_OFFSET;
            tx_left <= tx_count;
          end
        end
        pbc_pkg::TX_FEED: begin
          if (tx_done_i) begin
            tx_state <= pbc_pkg::TX_IDLE;
          end else if (txq_in.ready) begin
            tx_off <= tx_off + 1'b1;
            if (tx_off == pbc_pkg::PAGE_LAST) begin
              tx_page <= (tx_page == pbc_pkg::LAST_PAGE) ? split : tx_page + 1'b1;
            end
            tx_left <= tx_left - 1'b1;
            if (tx_left == 11'h001) tx_state <= pbc_pkg::TX_WAIT;
          end
        end
        default: begin
          if (tx_done_i) tx_state <= pbc_pkg::TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_req_o <= 1'b0;
      tx_mode_o <= 2'b00;
      tx_event_o <= 1'b0;
      rx_event_o <= 1'b0;
    end else begin
      tx_req_o <= tx_go;
      if (tx_go) tx_mode_o <= cmd[1:0];
      tx_event_o <= tx_fin;
      rx_event_o <= rx_push;
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  a_rbf_drop_frame: assert property (rx_state == pbc_pkg::RX_IDLE && rx_start_i && rx_buffer_full
      |=> rx_state == pbc_pkg::RX_DROP) else $error("frame accepted while buffer full");
  a_rbf_set_full: assert property (rx_state == pbc_pkg::RX_IDLE && rx_start_i
      && used >= {1'b0, split} |=> rx_buffer_full) else $error("full flag not set");
  a_rx_first_offset: assert property (rx_state == pbc_pkg::RX_IDLE && rx_start_i && rx_open
      |=> woff == pbc_pkg::DATA_OFFSET && wpage == $past(head)) else $error("bad start offset");
  a_rx_page_wrap: assert property (rx_state == pbc_pkg::RX_STORE && rx_valid_i && !rx_end_i
      && !do_flush && woff == pbc_pkg::PAGE_LAST && room && wpage == split - 1'b1
      |=> wpage == 5'h00) else $error("receive page did not wrap");
  a_tx_page_wrap: assert property (tx_state == pbc_pkg::TX_FEED && !tx_done_i && txq_in.ready
      && tx_off == pbc_pkg::PAGE_LAST && tx_page == pbc_pkg::LAST_PAGE
      |=> tx_page == $past(split)) else $error("transmit page did not wrap");
  a_csr_busy_hold: assert property (csr_wr_go || csr_rd_go
      |=> busy [*4] ##1 csr_busy == 3'h0) else $error("busy length wrong");
  a_rx_push_event: assert property (rx_push |=> rx_event_o ##1 !rx_event_o)
      else $error("receive event missing");
  a_tx_request: assert property (tx_go |=> tx_req_o && tx_mode_o == $past(cmd[1:0])
      ##1 !tx_req_o) else $error("transmit request wrong");
  a_reserved_cmd: assert property (wr_cmd && !cmd_known |=> $stable(last_cmd) && !tx_req_o
      && $stable(sleep_o)) else $error("reserved command acted");
  a_queue_pop: assert property (desc_out.ready && desc_out.valid
      |=> sfr_rdata_o == $past(desc_out.data)) else $error("pop data wrong");
  c_rx_packet: cover property (rx_push);
  c_tx_done: cover property (tx_fin);
  c_rbf_set: cover property (rbf_set);
  c_csr_read: cover property (csr_rd_go && csr_ok);
endmodule : packet_buffer_controller
`default_nettype wire

/* File: rtl/pbc_pkg.sv */
package pbc_pkg;
  localparam logic [7:0] SFR_CSR_DATA = 8'he3;
  localparam logic [7:0] SFR_CSR_ADDR = 8'he4;
  localparam logic [7:0] SFR_SPLIT = 8'he5;
  localparam logic [7:0] SFR_BUF_DATA = 8'he6;
  localparam logic [7:0] SFR_BUF_CMD = 8'he7;
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_INVALIDATE = 4'h2;
  localparam logic [3:0] CMD_FLUSH = 4'h3;
  localparam logic [3:0] CMD_TX_NORMAL = 4'h4;
  localparam logic [3:0] CMD_TX_NO_PAD = 4'h5;
  localparam logic [3:0] CMD_TX_NO_CRC = 4'h6;
  localparam logic [3:0] CMD_CSR_WRITE = 4'h8;
  localparam logic [3:0] CMD_CSR_READ = 4'h9;
  localparam logic [3:0] CMD_SLEEP_ON = 4'hc;
  localparam logic [3:0] CMD_SLEEP_OFF = 4'hd;
  localparam int MEM_BYTES = 8192;
  localparam logic [4:0] LAST_PAGE = 5'h1f;
  localparam logic [7:0] PAGE_LAST = 8'hff;
  localparam logic [7:0] DATA_OFFSET = 8'h04;
  localparam int STATUS_BYTES = 4;
  localparam int CSR_COUNT = 12;
  localparam int CSR_IDX_CTRL = 0;
  localparam int CSR_IDX_ADDR_HI = 1;
  localparam logic [7:0] CSR_LAST_ADDR = 8'h2c;
  localparam logic [2:0] CSR_BUSY_CYCLES = 3'h4;
  localparam logic [31:0] CSR_RST_CTRL = 32'h00040000;
  localparam logic [31:0] CSR_RST_ADDR_HI = 32'h0000ffff;
  localparam logic [31:0] CSR_RST_OTHER = 32'h00000000;
  localparam logic [4:0] SPLIT_RST = 5'h10;
  localparam int DESC_DEPTH = 31;
  localparam logic [2:0] MAX_PAGES = 3'h7;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_STORE = 2'b01, RX_DROP = 2'b11} rx_state_type;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_FEED = 2'b01, TX_WAIT = 2'b11} tx_state_type;
endpackage : pbc_pkg

/* File: rtl/byte_stream_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface byte_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic last;
  logic [W-1:0] data;
  modport src (output valid, output data, output last, input ready);
  modport snk (input valid, input data, input last, output ready);
endinterface : byte_stream_if
`default_nettype wire

/* File: rtl/desc_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module desc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = pbc_pkg::DESC_DEPTH
) (
  input wire logic mclk_i, // System clock.
  input wire logic nrst_i, // Asynchronous reset, active low.
  input wire logic flush_i, // Drops every entry.
  byte_stream_if.snk in_s, // Push side.
  byte_stream_if.src out_s // Pop side.
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wptr;
  logic [PW-1:0] rptr;
  logic [CW-1:0] count;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  assign in_s.ready = count != CW'(DEPTH);
  assign out_s.valid = count != '0;
  assign out_s.data = mem[rptr];
  assign out_s.last = 1'b0;
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wptr] <= in_s.data;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else if (flush_i) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (push) wptr <= bump(wptr);
      if (pop) rptr <= bump(rptr);
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end
endmodule : desc_fifo
`default_nettype wire

/* File: rtl/two_entry_buffer.sv */
`timescale 1ns/100ps
`default_nettype none
module two_entry_buffer #(
  parameter int W = 8
) (
  input wire logic mclk_i, // System clock.
  input wire logic nrst_i, // Asynchronous reset, active low.
  byte_stream_if.snk in_s, // Filling side.
  byte_stream_if.src out_s // Draining side.
);
  localparam logic [1:0] FULL = 2'h2;
  logic [W:0] slot0;
  logic [W:0] slot1;
  logic [1:0] count;
  logic push;
  logic pop;

  // Ready depends only on the count, so the drain side never combines into the fill side.
  assign in_s.ready = count != FULL;
  assign out_s.valid = count != 2'h0;
  assign out_s.last = slot0[W];
  assign out_s.data = slot0[W-1:0];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slot0 <= '0;
      slot1 <= '0;
      count <= 2'h0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (count == 2'h0) slot0 <= {in_s.last, in_s.data};
          else slot1 <= {in_s.last, in_s.data};
          count <= count + 1'b1;
        end
        2'b01: begin
          slot0 <= slot1;
          count <= count - 1'b1;
        end
        2'b11: begin
          if (count == 2'h1) begin
            slot0 <= {in_s.last, in_s.data};
          end else begin
            slot0 <= slot1;
            slot1 <= {in_s.last, in_s.data};
          end
        end
        default: count <= count;
      endcase
    end
  end
endmodule : two_entry_buffer
`default_nettype wire

/* File: sim/mac_model.sv */
`timescale 1ns/100ps
`default_nettype none
module mac_model (
  input wire logic mclk_i, // System clock.
  input wire logic nrst_i, // Reset, active low.
  input wire logic slow_i, // Stall on alternate cycles.
  input wire logic tx_valid_i, // Byte offered.
  input wire logic tx_last_i, // Final byte of frame.
  output logic tx_ready_o, // Byte taken.
  output logic tx_done_o, // Frame finished pulse.
  output logic [31:0] tx_status_o, // Status word.
  output int frame_bytes_o // Bytes taken in the last frame.
);
  int taken;
  logic [1:0] done_dly;
  // The status word keeps changing so a stale capture cannot match.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_ready_o <= 1'b0;
      done_dly <= 2'h0;
      taken <= 0;
      frame_bytes_o <= 0;
      tx_status_o <= 32'h0f0f0f0f;
    end else begin
      tx_ready_o <= slow_i ? !tx_ready_o : 1'b1;
      tx_status_o <= ~tx_status_o;
      done_dly <= {done_dly[0], tx_valid_i && tx_ready_o && tx_last_i};
      if (tx_valid_i && tx_ready_o) begin
        taken <= taken + 1;
      end
      if (done_dly[1]) begin
        frame_bytes_o <= taken;
        taken <= 0;
      end
    end
  end
  assign tx_done_o = done_dly[1];
endmodule : mac_model
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic mclk_i = 1'b0, nrst_i = 1'b0, wr = 1'b0, rd = 1'b0, slow = 1'b0;
  logic rx_start = 1'b0, rx_valid = 1'b0, rx_end = 1'b0, rx_ok = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rx_data = 8'h00, rdata, v8;
  logic [31:0] v32, mac_ctrl, tx_status;
  logic tx_req, tx_valid, tx_last, tx_ready, tx_done, rx_ev, tx_ev, sleep;
  logic [1:0] tx_mode, mode_seen;
  logic [7:0] tx_data, tx_byte;
  int bad_count = 0, total_checks = 0, rx_evs = 0, tx_evs = 0, frame_bytes;
  always #25 mclk_i = ~mclk_i;
  packet_buffer_controller i_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .sfr_addr_i(addr),
    .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
    .rx_start_i(rx_start), .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_end_i(rx_end),
    .rx_ok_i(rx_ok), .rx_status_i(32'h11223344), .tx_req_o(tx_req), .tx_mode_o(tx_mode),
    .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_last_o(tx_last), .tx_ready_i(tx_ready),
    .tx_done_i(tx_done), .tx_status_i(tx_status), .rx_event_o(rx_ev), .tx_event_o(tx_ev),
    .sleep_o(sleep), .mac_ctrl_o(mac_ctrl));
  mac_model i_mac (.mclk_i(mclk_i), .nrst_i(nrst_i), .slow_i(slow), .tx_valid_i(tx_valid),
    .tx_last_i(tx_last), .tx_ready_o(tx_ready), .tx_done_o(tx_done),
    .tx_status_o(tx_status), .frame_bytes_o(frame_bytes));
  // Event pulses last one cycle, so they are counted rather than sampled.
  always @(posedge mclk_i) begin
    if (rx_ev === 1'b1) rx_evs++;
    if (tx_ev === 1'b1) tx_evs++;
    if (tx_req === 1'b1) mode_seen = tx_mode;
    if (tx_valid === 1'b1 && tx_ready === 1'b1) tx_byte = tx_data;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge mclk_i);
    wr = 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_i);
    addr = a;
    rd = 1'b1;
    @(negedge mclk_i);
    rd = 1'b0;
    d = rdata;
  endtask : rd_reg
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic csr_cmd(input logic [7:0] a, input logic [7:0] c);
    wr_reg(8'he4, a);
    wr_reg(8'he7, c);
    rd_reg(8'he7, v8);
    check("busy", {4'h8, c[3:0]}, v8);
    for (int i = 0; i < 20 && v8[7] !== 1'b0; i++) rd_reg(8'he7, v8);
    check("idle", {4'h0, c[3:0]}, v8);
  endtask : csr_cmd
  task automatic csr_wr(input logic [7:0] a, input logic [31:0] d);
    for (int i = 3; i >= 0; i--) wr_reg(8'he3, d[8*i+:8]);
    csr_cmd(a, 8'h08);
  endtask : csr_wr
  task automatic csr_rd(input logic [7:0] a, output logic [31:0] d);
    csr_cmd(a, 8'h09);
    for (int i = 3; i >= 0; i--) rd_reg(8'he3, d[8*i+:8]);
  endtask : csr_rd
  task automatic rx_frame(input int n, input logic ok);
    @(negedge mclk_i);
    rx_start = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(negedge mclk_i);
      rx_start = 1'b0;
      rx_valid = 1'b1;
      rx_data = 8'(i);
    end
    @(negedge mclk_i);
    rx_valid = 1'b0;
    rx_end = 1'b1;
    rx_ok = ok;
    @(negedge mclk_i);
    rx_end = 1'b0;
    rx_ok = 1'b0;
    repeat (2) @(negedge mclk_i);
  endtask : rx_frame
  task automatic tx_send(input logic [10:0] n, input logic [4:0] pg, input logic [3:0] c);
    int target;
    target = tx_evs + 1;
    wr_reg(8'he6, {5'h00, n[10:8]});
    wr_reg(8'he6, n[7:0]);
    wr_reg(8'he6, {3'h0, pg});
    wr_reg(8'he7, {4'h0, c});
    for (int i = 0; i < 600 && tx_evs != target; i++) @(negedge mclk_i);
  endtask : tx_send
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  initial begin
    #1000000;
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (5) @(negedge mclk_i);
    nrst_i = 1'b1;
    rd_reg(8'he7, v8);
    check("command", 32'h00, v8);
    rd_reg(8'he5, v8);
    check("split", 32'h10, v8);
    check("mac control", 32'h00040000, mac_ctrl);
    csr_wr(8'h00, 32'h12345678);
    check("mac control", 32'h12345678, mac_ctrl);
    csr_wr(8'h2c, 32'hcafe0123);
    csr_rd(8'h2c, v32);
    check("csr 2c", 32'hcafe0123, v32);
    csr_wr(8'h30, 32'h5a5a5a5a);
    csr_rd(8'h30, v32);
    check("csr 30", 32'h0, v32);
    wr_reg(8'he7, 8'h0f);
    rd_reg(8'he7, v8);
    check("reserved", 32'h09, v8);
    wr_reg(8'he7, 8'h00);
    rd_reg(8'he7, v8);
    check("nop", 32'h00, v8);
    wr_reg(8'he7, 8'h0c);
    check("sleep", 32'h1, sleep);
    wr_reg(8'he7, 8'h0d);
    check("wake", 32'h0, sleep);
    rx_frame(5, 1'b1);
    rx_frame(2, 1'b0);
    check("rx events", 32'd1, rx_evs);
    rd_reg(8'he6, v8);
    check("descriptor", 32'h20, v8);
    rd_reg(8'he6, v8);
    check("empty queue", 32'h00, v8);
    wr_reg(8'he7, 8'h02);
    rx_frame(3, 1'b1);
    wr_reg(8'he7, 8'h03);
    rd_reg(8'he6, v8);
    check("flushed", 32'h00, v8);
    // With two receive pages the long frame starts on page 1 and wraps into page 0.
    wr_reg(8'he5, 8'h82);
    rd_reg(8'he5, v8);
    check("split set", 32'h82, v8);
    rx_frame(3, 1'b1);
    rd_reg(8'he6, v8);
    check("descriptor", 32'h20, v8);
    wr_reg(8'he7, 8'h02);
    rx_frame(300, 1'b1);
    rd_reg(8'he6, v8);
    check("wrapped", 32'h41, v8);
    rx_frame(3, 1'b1);
    rx_frame(3, 1'b1);
    rd_reg(8'he5, v8);
    check("full flag", 32'hc2, v8);
    check("rx events", 32'd4, rx_evs);
    // Page 0 holds bytes 0, 1, 2 and on from offset 4, so the sent bytes are known.
    wr_reg(8'he5, 8'h00);
    for (int m = 0; m < 3; m++) begin
      slow = m[0];
      tx_send(11'(3 + m), 5'h00, 4'(4 + m));
      check("tx mode", 32'(m), mode_seen);
      check("tx bytes", 32'(3 + m), frame_bytes);
      check("tx byte", 32'(2 + m), tx_byte);
      check("tx events", 32'(m + 1), tx_evs);
    end
    tx_send(11'h104, 5'h1f, 4'h4);
    check("wrap bytes", 32'h104, frame_bytes);
    check("wrap byte", 32'h03, tx_byte);
    check("tx events", 32'd4, tx_evs);
    finish_test();
  end
endmodule : tb
`default_nettype wire
